// [rtl/rtcm_pkg.sv]
package rtcm_pkg;
  // Address map on the five-bit parallel port
  localparam logic [4:0] ADDR_MAIN_STATUS   = 5'h00;
  localparam logic [4:0] ADDR_MODE_CTRL     = 5'h01;
  localparam logic [4:0] ADDR_OUT_SELECT    = 5'h02;
  localparam logic [4:0] ADDR_FLAG_OR_IEN   = 5'h03;
  localparam logic [4:0] ADDR_SAVE_OR_ICR1  = 5'h04;
  // Main status fields
  localparam int MS_PENDING   = 0;
  localparam int MS_POWER_LOSS_INPUT     = 1;
  localparam int MS_PERIODIC  = 2;
  localparam int MS_ALARM     = 3;
  localparam int MS_BLOCK_SEL = 6;
  localparam logic [7:0] MS_RAM_MASK = 8'hb0;
  // Rollover flag register fields
  localparam int FL_SUPPLY    = 6;
  localparam int FL_TEST      = 7;
  // Time snapshot control fields
  localparam int TS_UNUSED    = 6;
  localparam int TS_ENABLE    = 7;
  // Clock mode fields
  localparam int CM_LEAP_LO   = 0;
  localparam int CM_LEAP_HI   = 1;
  localparam int CM_HOUR12    = 2;
  localparam int CM_START     = 3;
  localparam int CM_STBY_INT  = 4;
  // Output select and interrupt control one fields
  localparam int OS_CRYSTAL   = 7;
  localparam int I1_ALARM_EN  = 6;
  localparam int I1_POWER_LOSS_INPUT_EN  = 7;
  localparam int NUM_ROLL     = 6;
  // Reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic       RST_OSC_FAIL  = 1'b1;
  localparam logic       RST_SUPPLY    = 1'b1;
endpackage : rtcm_pkg

// [rtl/rtcm_mode_flags.sv]
module rtcm_mode_flags
  import rtcm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [4:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        rd_en,
  input  wire logic        wr_en,
  input  wire logic [5:0]  rollover_tick,
  input  wire logic        year_end_tick,
  input  wire logic        alarm_match,
  input  wire logic        osc_running,
  input  wire logic        osc_fail_event,
  input  wire logic        on_battery,
  input  wire logic        power_loss_input_n,
  input  wire logic        crystal_input,
  output logic [7:0]       rdata_q,
  output logic             interrupt_pin_n_q,
  output logic             multi_function_output_q,
  output logic             multi_function_output_oe_q,
  output logic             counter_run_q,
  output logic             hour12_mode_q,
  output logic [1:0]       leap_count_q,
  output logic             feb29_allowed_q,
  output logic             time_save_follow_q,
  output logic             single_supply_q,
  output logic             test_reg_enable_q
);

  logic [7:0] main_ram_q;
  logic       block_sel_q;
  logic       st_power_loss_input_q;
  logic       st_periodic_q;
  logic       st_alarm_q;
  logic [5:0] roll_flag_q;
  logic       osc_fail_q;
  logic       supply_q;
  logic       test_q;
  logic [7:0] save_ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] out_sel_q;
  logic [7:0] ien0_q;
  logic [7:0] ien1_q;
  logic       on_batt_q;
  logic       pend_pin;
  logic       pend_mfo;
  logic       stby_enter;

  function automatic logic hit(input logic [4:0] a, input logic blk, input logic [4:0] ra, input logic rb);
    hit = (a == ra) && (blk == rb);
  endfunction : hit

  wire wr_main  = wr_en && (addr == ADDR_MAIN_STATUS);
  wire wr_flag  = wr_en && hit(addr, block_sel_q, ADDR_FLAG_OR_IEN, 1'b0);
  wire wr_save  = wr_en && hit(addr, block_sel_q, ADDR_SAVE_OR_ICR1, 1'b0);
  wire wr_mode  = wr_en && hit(addr, block_sel_q, ADDR_MODE_CTRL, 1'b1);
  wire wr_osel  = wr_en && hit(addr, block_sel_q, ADDR_OUT_SELECT, 1'b1);
  wire wr_ien0  = wr_en && hit(addr, block_sel_q, ADDR_FLAG_OR_IEN, 1'b1);
  wire wr_ien1  = wr_en && hit(addr, block_sel_q, ADDR_SAVE_OR_ICR1, 1'b1);
  wire rd_flag  = rd_en && hit(addr, block_sel_q, ADDR_FLAG_OR_IEN, 1'b0);
  wire start_ok = wr_mode && wdata[CM_START] && osc_running && !osc_fail_event;

  assign stby_enter = on_battery && !on_batt_q;
  assign pend_pin   = st_periodic_q || (st_alarm_q && ien1_q[I1_ALARM_EN]);
  assign pend_mfo   = !out_sel_q[OS_CRYSTAL] && st_power_loss_input_q && ien1_q[I1_POWER_LOSS_INPUT_EN];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      on_batt_q <= 1'b0;
    end else begin
      on_batt_q <= on_battery;
    end
  end

  // Main status: block select, write-one-clear periodic and alarm status, power loss status following the pin, spare storage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      main_ram_q    <= RST_ZERO;
      block_sel_q   <= 1'b0;
      st_power_loss_input_q    <= 1'b0;
      st_periodic_q <= 1'b0;
      st_alarm_q    <= 1'b0;
    end else begin
      if (wr_main) begin
        main_ram_q  <= wdata & MS_RAM_MASK;
        block_sel_q <= wdata[MS_BLOCK_SEL];
      end
      if (!power_loss_input_n) begin
        st_power_loss_input_q <= 1'b1;
      end else begin
        st_power_loss_input_q <= 1'b0;
      end
      if (|(rollover_tick & ien0_q[5:0])) begin
        st_periodic_q <= 1'b1;
      end else if (wr_main && wdata[MS_PERIODIC]) begin
        st_periodic_q <= 1'b0;
      end
      if (alarm_match) begin
        st_alarm_q <= 1'b1;
      end else if (wr_main && wdata[MS_ALARM]) begin
        st_alarm_q <= 1'b0;
      end
    end
  end

  // Rollover change flags, set wins over read clear
  generate
    for (genvar i = 0; i < NUM_ROLL; i++) begin : g_flag
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          roll_flag_q[i] <= 1'b0;
        end else if (rollover_tick[i]) begin
          roll_flag_q[i] <= 1'b1;
        end else if (rd_flag) begin
          roll_flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Oscillator fail flag and supply mode share bit 6
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_fail_q <= RST_OSC_FAIL;
      supply_q   <= RST_SUPPLY;
      test_q     <= 1'b0;
    end else begin
      if (osc_fail_event) begin
        osc_fail_q <= 1'b1;
      end else if (start_ok) begin
        osc_fail_q <= 1'b0;
      end
      if (osc_fail_event) begin
        supply_q <= 1'b1;
      end else if (wr_flag) begin
        supply_q <= wdata[FL_SUPPLY];
      end
      if (wr_flag) begin
        test_q <= wdata[FL_TEST];
      end
    end
  end

  // Snapshot control and clock mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      save_ctrl_q <= RST_ZERO;
      mode_q      <= RST_ZERO;
    end else begin
      if (stby_enter) begin
        save_ctrl_q[TS_ENABLE] <= 1'b0;
      end else if (wr_save) begin
        save_ctrl_q[TS_ENABLE] <= wdata[TS_ENABLE];
      end
      if (wr_save) begin
        save_ctrl_q[5:0] <= wdata[5:0];
      end
      save_ctrl_q[TS_UNUSED] <= 1'b0;
      if (wr_mode) begin
        mode_q[7:5]           <= wdata[7:5];
        mode_q[CM_STBY_INT]   <= wdata[CM_STBY_INT];
        mode_q[CM_HOUR12]     <= wdata[CM_HOUR12];
      end
      if (wr_mode) begin
        mode_q[CM_LEAP_HI:CM_LEAP_LO] <= wdata[CM_LEAP_HI:CM_LEAP_LO];
      end else if (year_end_tick) begin
        mode_q[CM_LEAP_HI:CM_LEAP_LO] <= mode_q[CM_LEAP_HI:CM_LEAP_LO] + 2'b01;
      end
      if (osc_fail_event) begin
        mode_q[CM_START] <= 1'b0;
      end else if (wr_mode) begin
        mode_q[CM_START] <= start_ok;
      end
    end
  end

  // Output select and interrupt enables; ien0_q[5:0] and ien1_q[7:6] dropped on standby entry unless CM_STBY_INT is set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_sel_q <= RST_ZERO;
      ien0_q    <= RST_ZERO;
      ien1_q    <= RST_ZERO;
    end else begin
      if (wr_osel) begin
        out_sel_q <= wdata;
      end
      if (stby_enter && !mode_q[CM_STBY_INT]) begin
        ien0_q[5:0] <= 6'h00;
      end else if (wr_ien0) begin
        ien0_q[5:0] <= wdata[5:0];
      end
      if (wr_ien0) begin
        ien0_q[7:6] <= wdata[7:6];
      end
      if (stby_enter && !mode_q[CM_STBY_INT]) begin
        ien1_q[7:6] <= 2'b00;
      end else if (wr_ien1) begin
        ien1_q[7:6] <= wdata[7:6];
      end
      if (wr_ien1) begin
        ien1_q[5:0] <= wdata[5:0];
      end
    end
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= RST_ZERO;
    end else if (rd_en) begin
      if (addr == ADDR_MAIN_STATUS) begin
        rdata_q <= main_ram_q | {1'b0, block_sel_q, 2'b00, st_alarm_q, st_periodic_q, st_power_loss_input_q,
                                 pend_pin || pend_mfo};
      end else if (hit(addr, block_sel_q, ADDR_FLAG_OR_IEN, 1'b0)) begin
        rdata_q <= {test_q, osc_fail_q, roll_flag_q};
      end else if (hit(addr, block_sel_q, ADDR_SAVE_OR_ICR1, 1'b0)) begin
        rdata_q <= save_ctrl_q;
      end else if (hit(addr, block_sel_q, ADDR_MODE_CTRL, 1'b1)) begin
        rdata_q <= mode_q;
      end else if (hit(addr, block_sel_q, ADDR_OUT_SELECT, 1'b1)) begin
        rdata_q <= out_sel_q;
      end else if (hit(addr, block_sel_q, ADDR_FLAG_OR_IEN, 1'b1)) begin
        rdata_q <= ien0_q;
      end else if (hit(addr, block_sel_q, ADDR_SAVE_OR_ICR1, 1'b1)) begin
        rdata_q <= ien1_q;
      end else begin
        rdata_q <= RST_ZERO;
      end
    end
  end

  // Pins and control levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interrupt_pin_n_q          <= 1'b1;
      multi_function_output_q    <= 1'b0;
      multi_function_output_oe_q <= 1'b0;
      counter_run_q              <= 1'b0;
      hour12_mode_q              <= 1'b0;
      leap_count_q               <= 2'b00;
      feb29_allowed_q            <= 1'b0;
      time_save_follow_q         <= 1'b0;
      single_supply_q            <= RST_SUPPLY;
      test_reg_enable_q          <= 1'b0;
    end else begin
      interrupt_pin_n_q <= !pend_pin;
      if (out_sel_q[OS_CRYSTAL]) begin
        multi_function_output_q    <= crystal_input;
        multi_function_output_oe_q <= !on_battery || !crystal_input;
      end else begin
        multi_function_output_q    <= 1'b0;
        multi_function_output_oe_q <= pend_mfo;
      end
      counter_run_q      <= mode_q[CM_START];
      hour12_mode_q      <= mode_q[CM_HOUR12];
      leap_count_q       <= mode_q[CM_LEAP_HI:CM_LEAP_LO];
      feb29_allowed_q    <= (mode_q[CM_LEAP_HI:CM_LEAP_LO] == 2'b00);
      time_save_follow_q <= save_ctrl_q[TS_ENABLE];
      single_supply_q    <= supply_q;
      test_reg_enable_q  <= test_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_flag_set_roll: assert property (rollover_tick[0] |=> roll_flag_q[0])
    else $error("Rollover did not set flag");
  a_flag_read_clear: assert property (rd_flag && rollover_tick == 6'h00 |=> roll_flag_q == 6'h00)
    else $error("Flag read did not clear flags");
  a_flag_write_ignored: assert property (wr_flag && !rd_en && rollover_tick == 6'h00 |=> $stable(roll_flag_q))
    else $error("Write changed rollover flags");
  a_osc_fail_force: assert property (osc_fail_event |=> osc_fail_q && !mode_q[CM_START] ##1 !counter_run_q)
    else $error("Oscillator fail not forced");
  a_osc_fail_clear: assert property (start_ok |=> !osc_fail_q && mode_q[CM_START])
    else $error("Start did not clear fail flag");
  a_start_needs_osc: assert property (wr_mode && !osc_running |=> !mode_q[CM_START])
    else $error("Start taken without oscillator");
  a_save_bit_zero: assert property (rd_en && hit(addr, block_sel_q, ADDR_SAVE_OR_ICR1, 1'b0) |=> !rdata_q[TS_UNUSED])
    else $error("Unused snapshot bit read as one");
  a_snapshot_freeze: assert property (stby_enter |=> !save_ctrl_q[TS_ENABLE] ##1 !time_save_follow_q)
    else $error("Snapshot enable not cleared on battery");
  a_standby_clear: assert property (stby_enter && !mode_q[CM_STBY_INT] |=> ien0_q[5:0] == 6'h00 && ien1_q[7:6] == 2'b00)
    else $error("Enables kept in standby");
  a_no_periodic: assert property (ien0_q[5:0] == 6'h00 && !st_periodic_q |=> !st_periodic_q)
    else $error("Periodic status with enables off");
  a_leap_step: assert property (year_end_tick && !wr_mode |=> mode_q[1:0] == $past(mode_q[1:0]) + 2'b01)
    else $error("Leap count did not step");
  a_leap_feb29: assert property (mode_q[1:0] == 2'b00 |=> feb29_allowed_q)
    else $error("Leap year did not allow day 29");
  a_test_unlock: assert property (wr_flag && wdata[FL_TEST] |=> test_q)
    else $error("Test unlock bit not stored");
  a_supply_select: assert property (wr_flag && !osc_fail_event && !wdata[FL_SUPPLY] |=> !supply_q)
    else $error("Battery supply mode not selected");
  a_hour_mode: assert property (wr_mode && wdata[CM_HOUR12] |=> mode_q[CM_HOUR12] ##1 hour12_mode_q)
    else $error("Twelve hour mode not applied");
  a_start_runs: assert property (mode_q[CM_START] |=> counter_run_q)
    else $error("Counter chain not running");
  a_stop_halts: assert property (!mode_q[CM_START] |=> !counter_run_q)
    else $error("Counter chain not halted");
  a_snapshot_track: assert property (save_ctrl_q[TS_ENABLE] |=> time_save_follow_q)
    else $error("Snapshot not following clock");
  a_periodic_set: assert property (|(rollover_tick & ien0_q[5:0]) |=> st_periodic_q)
    else $error("Enabled rollover did not set periodic status");
  a_status_clear: assert property (wr_main && wdata[MS_PERIODIC] && !(|(rollover_tick & ien0_q[5:0]))
    |=> !st_periodic_q)
    else $error("Periodic status not cleared by write one");
  a_block_select: assert property (wr_main && wdata[MS_BLOCK_SEL] |=> block_sel_q)
    else $error("Register block not selected");
  a_pin_periodic: assert property (st_periodic_q |=> !interrupt_pin_n_q)
    else $error("Periodic status did not drive interrupt pin");
  a_mfo_crystal: assert property (out_sel_q[OS_CRYSTAL] |=> multi_function_output_q == $past(crystal_input))
    else $error("Crystal copy not on output");
  a_mfo_open_drain: assert property (!out_sel_q[OS_CRYSTAL] |=> !multi_function_output_q)
    else $error("Interrupt output drove high");
endmodule : rtcm_mode_flags

// [test/rtcm_host.sv]
module rtcm_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata_q,
  output logic      [4:0] addr,
  output logic      [7:0] wdata,
  output logic            rd_en,
  output logic            wr_en
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr  = 5'h1f;
    wdata = 8'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
  end

  // Host writes one byte: wr_en strobed for one cycle, then address and data inverted
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    addr  = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    addr  = ~a;
    d     = rdata_q;
  endtask : rd
endmodule : rtcm_host

// [test/test_rtc_mode_and_flag_registers.sv]
module test_rtc_mode_and_flag_registers;
  import rtcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk, reset, year_end_tick, alarm_match, osc_running, osc_fail_event;
  logic       on_battery, power_loss_input_n, crystal_input;
  logic [5:0] rollover_tick;
  logic [4:0] addr;
  logic [7:0] wdata, rdata_q, v;
  logic       rd_en, wr_en, interrupt_pin_n_q, multi_function_output_q, multi_function_output_oe_q;
  logic       counter_run_q, hour12_mode_q, feb29_allowed_q, time_save_follow_q;
  logic       single_supply_q, test_reg_enable_q;
  logic [1:0] leap_count_q;
  logic [31:0] seed = 32'd78066;
  logic [5:0] flg;
  logic       blk;
  int         bad_count, samples_checked, cycles;

  rtcm_mode_flags DUT (.clk, .reset, .addr, .wdata, .rd_en, .wr_en, .rollover_tick, .year_end_tick,
    .alarm_match, .osc_running, .osc_fail_event, .on_battery, .power_loss_input_n, .crystal_input,
    .rdata_q, .interrupt_pin_n_q, .multi_function_output_q, .multi_function_output_oe_q,
    .counter_run_q, .hour12_mode_q, .leap_count_q, .feb29_allowed_q, .time_save_follow_q,
    .single_supply_q, .test_reg_enable_q);

  rtcm_host HOST (.clk, .rdata_q, .addr, .wdata, .rd_en, .wr_en);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t pin %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    HOST.rd(a, v);
    chk8(v, exp);
    if (a == ADDR_FLAG_OR_IEN && !blk) flg = '0;
  endtask : rchk

  task automatic wmain(input logic [7:0] d);
    HOST.wr(ADDR_MAIN_STATUS, d);
    blk = d[MS_BLOCK_SEL];
  endtask : wmain

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic tick(input logic [5:0] t);
    @(negedge clk);
    rollover_tick = t;
    flg |= t;
    @(negedge clk);
    rollover_tick = '0;
  endtask : tick

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    reset = 1'b1;
    {year_end_tick, alarm_match, osc_running, osc_fail_event, on_battery, crystal_input} = '0;
    power_loss_input_n = 1'b1;
    rollover_tick = '0;
    flg = '0;
    blk = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk1(single_supply_q, 1'b1);
    rchk(ADDR_FLAG_OR_IEN, 8'h40);
    v = 8'(xs());
    HOST.wr(ADDR_SAVE_OR_ICR1, v);
    rchk(ADDR_SAVE_OR_ICR1, v & 8'hbf);
    chk1(time_save_follow_q, v[7]);
    HOST.wr(ADDR_SAVE_OR_ICR1, 8'h80);
    on_battery = 1'b1;
    cyc(3);
    rchk(ADDR_SAVE_OR_ICR1, 8'h00);
    on_battery = 1'b0;
    HOST.wr(ADDR_FLAG_OR_IEN, 8'hff);
    cyc(1);
    chk1(test_reg_enable_q, 1'b1);
    rchk(ADDR_FLAG_OR_IEN, 8'hc0);
    HOST.wr(ADDR_FLAG_OR_IEN, 8'h00);
    cyc(1);
    chk1(single_supply_q, 1'b0);
    for (int i = 0; i < 4; i++) begin
      tick(6'(xs()));
      tick(6'(xs()));
      rchk(ADDR_FLAG_OR_IEN, {2'b01, flg});
      rchk(ADDR_FLAG_OR_IEN, 8'h40);
    end
    wmain(8'h40);
    HOST.wr(ADDR_MODE_CTRL, 8'h08);
    rchk(ADDR_MODE_CTRL, 8'h00);
    osc_running = 1'b1;
    HOST.wr(ADDR_MODE_CTRL, 8'hef);
    rchk(ADDR_MODE_CTRL, 8'hef);
    chk1(counter_run_q, 1'b1);
    chk1(hour12_mode_q, 1'b1);
    chk1(feb29_allowed_q, 1'b0);
    chk1(leap_count_q[1], 1'b1);
    chk1(leap_count_q[0], 1'b1);
    @(negedge clk) year_end_tick = 1'b1;
    @(negedge clk) year_end_tick = 1'b0;
    rchk(ADDR_MODE_CTRL, 8'hec);
    chk1(feb29_allowed_q, 1'b1);
    chk1(leap_count_q[1], 1'b0);
    chk1(leap_count_q[0], 1'b0);
    wmain(8'h00);
    rchk(ADDR_FLAG_OR_IEN, 8'h00);
    wmain(8'h40);
    v = 8'(xs());
    HOST.wr(ADDR_OUT_SELECT, {1'b1, v[6:0]});
    rchk(ADDR_OUT_SELECT, {1'b1, v[6:0]});
    for (int i = 0; i < 4; i++) begin
      crystal_input = i[0];
      cyc(2);
      chk1(multi_function_output_q, i[0]);
      chk1(multi_function_output_oe_q, 1'b1);
    end
    HOST.wr(ADDR_FLAG_OR_IEN, 8'h00);
    tick(6'h3f);
    cyc(2);
    chk1(interrupt_pin_n_q, 1'b1);
    HOST.wr(ADDR_FLAG_OR_IEN, 8'hc4);
    tick(6'h01);
    cyc(2);
    chk1(interrupt_pin_n_q, 1'b1);
    tick(6'h04);
    cyc(2);
    chk1(interrupt_pin_n_q, 1'b0);
    rchk(ADDR_MAIN_STATUS, 8'h45);
    wmain(8'h44);
    cyc(2);
    chk1(interrupt_pin_n_q, 1'b1);
    rchk(ADDR_MAIN_STATUS, 8'h40);
    HOST.wr(ADDR_SAVE_OR_ICR1, 8'hff);
    on_battery = 1'b1;
    cyc(3);
    rchk(ADDR_FLAG_OR_IEN, 8'hc0);
    rchk(ADDR_SAVE_OR_ICR1, 8'h3f);
    on_battery = 1'b0;
    HOST.wr(ADDR_SAVE_OR_ICR1, 8'h80);
    HOST.wr(ADDR_OUT_SELECT, 8'h00);
    power_loss_input_n = 1'b0;
    cyc(3);
    chk1(multi_function_output_q, 1'b0);
    chk1(multi_function_output_oe_q, 1'b1);
    rchk(ADDR_MAIN_STATUS, 8'h43);
    power_loss_input_n = 1'b1;
    cyc(3);
    chk1(multi_function_output_oe_q, 1'b0);
    HOST.wr(ADDR_SAVE_OR_ICR1, 8'h40);
    @(negedge clk) alarm_match = 1'b1;
    @(negedge clk) alarm_match = 1'b0;
    cyc(2);
    chk1(interrupt_pin_n_q, 1'b0);
    wmain(8'h48);
    cyc(2);
    chk1(interrupt_pin_n_q, 1'b1);
    @(negedge clk) osc_fail_event = 1'b1;
    @(negedge clk) osc_fail_event = 1'b0;
    cyc(2);
    chk1(counter_run_q, 1'b0);
    chk1(single_supply_q, 1'b1);
    wmain(8'h00);
    rchk(ADDR_FLAG_OR_IEN, {2'b01, flg});
    final_report();
  end
endmodule : test_rtc_mode_and_flag_registers
